/* File: rtl/dag_pkg.sv */
/*
  Package of the DSP data address generator: register map, field layout,
  reset values, update modes, operand codes and the packed carriers.
  Assumes a single core clock and an APB register bus with 32-bit data.
*/
package dag_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0]  DAG_OFS_STATUS_REG  = 8'h00;
  localparam logic [7:0]  DAG_OFS_MOD_CTRL    = 8'h04;
  localparam logic [7:0]  DAG_OFS_STATE       = 8'h08;
  localparam logic [7:0]  DAG_OFS_GPR_BASE    = 8'h20;
  localparam logic [7:0]  DAG_OFS_GPR_LAST    = 8'h3C;
  localparam int          DAG_ADDR_W          = 8;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int          DAG_BIT_XMOD        = 0;
  localparam int          DAG_BIT_YMOD        = 1;
  localparam int          DAG_BIT_PENDING     = 0;
  localparam int          DAG_BIT_OPERR       = 1;
  localparam logic [31:0] DAG_RST_WORD        = 32'h0000_0000;
  localparam logic [1:0]  DAG_RST_MODE        = 2'h0;

  // ==========================================================================
  // General registers held here and their roles
  // ==========================================================================
  localparam int          DAG_GPR_LO          = 2;
  localparam int          DAG_GPR_HI          = 9;
  localparam logic [3:0]  DAG_SINGLE_BASE     = 4'h2;
  localparam logic [3:0]  DAG_X_BASE          = 4'h4;
  localparam logic [3:0]  DAG_Y_BASE          = 4'h6;
  localparam logic [3:0]  DAG_X_INDEX         = 4'h8;
  localparam logic [3:0]  DAG_Y_INDEX         = 4'h9;
  localparam logic [3:0]  DAG_SINGLE_INDEX    = 4'h8;

  // ==========================================================================
  // Address steps
  // ==========================================================================
  localparam logic [31:0] DAG_STEP_WORD       = 32'h0000_0002;
  localparam logic [31:0] DAG_STEP_LONG       = 32'h0000_0004;

  // ==========================================================================
  // Update modes and operand codes
  // ==========================================================================
  typedef enum logic [1:0] {
    DAG_UPD_NOP = 2'h0,
    DAG_UPD_INC = 2'h1,
    DAG_UPD_IDX = 2'h2,
    DAG_UPD_DEC = 2'h3
  } dag_upd_t;

  // Single operand codes 0..4 and 6 are reserved
  localparam logic [15:0] DAG_OPND_LEGAL      = 16'hFFA0;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic       en;
    logic       sel;
    dag_upd_t   mode;
    logic       store;
    logic       data_sel;
  } dag_dual_op_t;

  typedef struct packed {
    logic         single;
    dag_dual_op_t x;
    dag_dual_op_t y;
    logic [1:0]   s_sel;
    dag_upd_t     s_mode;
    logic         s_long;
    logic         s_store;
    logic [3:0]   s_opnd;
  } dag_op_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        data_sel;
    logic [14:0] addr;
  } dag_xy_acc_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        long_word;
    logic [3:0]  opnd;
    logic [31:0] addr;
  } dag_single_acc_t;

  typedef enum logic [1:0] {
    DAG_ST_IDLE = 2'b00,
    DAG_ST_WAIT = 2'b01
  } dag_state_t;

endpackage

/* File: rtl/dag_core.sv */
/*
  DSP data address generator: pointer registers, modulo wrap, dual X/Y and
  single transfer addressing, APB register access.
  Assumes an execute-stage operation port synchronous to sys_clk_in and an
  internal bus that grants single accesses with idb_grant_in.
*/
// The address map and the APB register port were left to the implementer.
// Operation
// - X pointer R4/R5, Y pointer R6/R7, parallel
// - Index R8 for X, R9 for Y
// - Dual update: none, add index, add two
// - Dual access uses pointer before update
// - Dual words; pointer bits 1..15 address
// - Dual update writes lower word only
// - Single pointer R2..R5, index R8
// - Post-increment by two or four, old address
// - Pre-decrement by two or four, new address
// - Single on internal bus, may wait; dual never
// - Single operand any DSP register; dual restricted
// - Modulo only dual, per-pointer enable bits
// - Both enables set: Y pointer only
// - Lower word equals end: load start, else add
// - Index stepping past end does not wrap
// - No-update mode skips modulo check
// - C008..C00C increments wrap back to C008
// - All updates in one execute cycle
`timescale 1ns/1ps

module dag_core
  import dag_pkg::*;
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [DAG_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic                       pready_out,
  output logic [31:0]                prdata_out,
  output logic                       pslverr_out,
  input  wire logic                  op_valid_in,
  input  wire dag_op_t               op_in,
  output logic                       op_ready_out,
  output logic                       op_err_out,
  output dag_xy_acc_t                x_acc_out,
  output dag_xy_acc_t                y_acc_out,
  output dag_single_acc_t            s_acc_out,
  input  wire logic                  idb_grant_in
);

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  // Returns {hit, writable, code}; code 0..2 are control words, 8..15 GPRs
  function automatic logic [5:0] dag_decode(input logic [DAG_ADDR_W-1:0] a);
    logic [5:0] r;
    r = 6'h00;
    if (a == DAG_OFS_STATUS_REG)
      r = 6'h30;
    else if (a == DAG_OFS_MOD_CTRL)
      r = 6'h31;
    else if (a == DAG_OFS_STATE)
      r = 6'h22;
    else if (a >= DAG_OFS_GPR_BASE && a <= DAG_OFS_GPR_LAST && a[1:0] == 2'h0)
      r = {2'b11, 1'b1, 3'(a[4:2])};
    return r;
  endfunction

  // Dual pointer update: lower word only, optional modulo wrap
  function automatic logic [31:0] dag_dual_next(input logic [31:0] ptr,
                                               input logic [31:0] step,
                                               input logic        use_mod,
                                               input logic [31:0] modc);
    logic [15:0] lo;
    lo = ptr[15:0] + step[15:0];
    if (use_mod && ptr[15:0] == modc[31:16])
      lo = modc[15:0];
    return {ptr[31:16], lo};
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  logic [31:0]     gpr_q [DAG_GPR_LO:DAG_GPR_HI];
  logic [31:0]     gpr_d [DAG_GPR_LO:DAG_GPR_HI];
  logic [1:0]      ctrl_q, ctrl_d;
  logic [31:0]     modc_q, modc_d;
  dag_state_t      state_q, state_d;
  logic            pready_q, pready_d;
  logic            pslverr_q, pslverr_d;
  logic [31:0]     prdata_q, prdata_d;
  logic            oprdy_q, oprdy_d;
  logic            operr_q, operr_d;
  dag_xy_acc_t     xacc_q, xacc_d, yacc_q, yacc_d;
  dag_single_acc_t sacc_q, sacc_d;

  // ==========================================================================
  // Operation decode
  // ==========================================================================
  logic        op_go, dual_go, single_go;
  logic        x_mod_eff, y_mod_eff;
  logic [3:0]  x_idx, y_idx, s_idx;
  logic [31:0] x_ptr_cur, y_ptr_cur, s_ptr_cur;
  logic [31:0] x_step, y_step, s_step, s_len;
  logic [31:0] x_new, y_new, s_new;
  logic [14:0] x_ptr_word, y_ptr_word;
  logic        dual_bad, single_bad;

  assign op_go     = op_valid_in && oprdy_q;
  assign dual_go   = op_go && !op_in.single;
  assign single_go = op_go && op_in.single;

  assign y_mod_eff = ctrl_q[DAG_BIT_YMOD];
  assign x_mod_eff = ctrl_q[DAG_BIT_XMOD] && !ctrl_q[DAG_BIT_YMOD];

  assign x_idx = DAG_X_BASE + {3'h0, op_in.x.sel};
  assign y_idx = DAG_Y_BASE + {3'h0, op_in.y.sel};
  assign s_idx = DAG_SINGLE_BASE + {2'h0, op_in.s_sel};

  assign x_ptr_cur  = gpr_q[x_idx];
  assign y_ptr_cur  = gpr_q[y_idx];
  assign s_ptr_cur  = gpr_q[s_idx];
  assign x_ptr_word = x_ptr_cur[15:1];
  assign y_ptr_word = y_ptr_cur[15:1];

  assign x_step = (op_in.x.mode == DAG_UPD_IDX) ? gpr_q[DAG_X_INDEX]
                                                : DAG_STEP_WORD;
  assign y_step = (op_in.y.mode == DAG_UPD_IDX) ? gpr_q[DAG_Y_INDEX]
                                                : DAG_STEP_WORD;
  assign s_len  = op_in.s_long ? DAG_STEP_LONG : DAG_STEP_WORD;
  assign s_step = (op_in.s_mode == DAG_UPD_IDX) ? gpr_q[DAG_SINGLE_INDEX] : s_len;

  // No-update leaves the pointer and skips the wrap check
  assign x_new = (op_in.x.mode == DAG_UPD_NOP) ? x_ptr_cur
               : dag_dual_next(x_ptr_cur, x_step, x_mod_eff, modc_q);
  assign y_new = (op_in.y.mode == DAG_UPD_NOP) ? y_ptr_cur
               : dag_dual_next(y_ptr_cur, y_step, y_mod_eff, modc_q);

  always_comb
  begin
    unique case (op_in.s_mode)
      DAG_UPD_NOP: s_new = s_ptr_cur;
      DAG_UPD_DEC: s_new = s_ptr_cur - s_len;
      default:     s_new = s_ptr_cur + s_step;
    endcase
  end

  // Dual transfers have no pre-decrement; single operand codes have holes
  assign dual_bad   = (op_in.x.en && op_in.x.mode == DAG_UPD_DEC)
                   || (op_in.y.en && op_in.y.mode == DAG_UPD_DEC);
  assign single_bad = !DAG_OPND_LEGAL[op_in.s_opnd];

  // ==========================================================================
  // APB slave
  // ==========================================================================
  logic [5:0] dec;
  logic       apb_access, apb_commit;

  assign dec        = dag_decode(paddr_in);
  assign apb_access = psel_in && penable_in && !pready_q;
  assign apb_commit = psel_in && penable_in && pready_q;

  always_comb
  begin
    pready_d  = apb_access;
    pslverr_d = pslverr_q;
    prdata_d  = prdata_q;
    if (apb_access)
    begin
      pslverr_d = !dec[5] || (pwrite_in && !dec[4]);
      prdata_d  = DAG_RST_WORD;
      if (!pwrite_in && dec[5])
      begin
        if (dec[3])
          prdata_d = gpr_q[DAG_GPR_LO + int'(dec[2:0])];
        else if (dec[2:0] == 3'h0)
          prdata_d = {30'h0, ctrl_q};
        else if (dec[2:0] == 3'h1)
          prdata_d = modc_q;
        else
          prdata_d = {30'h0, operr_q, state_q == DAG_ST_WAIT};
      end
    end
    else if (!psel_in)
    begin
      pslverr_d = 1'b0;
    end
  end

  // ==========================================================================
  // Register file: APB writes first, execute-stage updates override
  // ==========================================================================
  always_comb
  begin
    for (int i = DAG_GPR_LO; i <= DAG_GPR_HI; i++)
      gpr_d[i] = gpr_q[i];
    ctrl_d = ctrl_q;
    modc_d = modc_q;
    if (apb_commit && pwrite_in && dec[5] && dec[4])
    begin
      if (dec[3])
        gpr_d[DAG_GPR_LO + int'(dec[2:0])] = pwdata_in;
      else if (dec[2:0] == 3'h0)
        ctrl_d = pwdata_in[1:0];
      else
        modc_d = pwdata_in;
    end
    if (dual_go && !dual_bad)
    begin
      if (op_in.x.en)
        gpr_d[x_idx] = x_new;
      if (op_in.y.en)
        gpr_d[y_idx] = y_new;
    end
    if (single_go && !single_bad)
      gpr_d[s_idx] = s_new;
  end

  // ==========================================================================
  // Access issue and bus contention
  // ==========================================================================
  always_comb
  begin
    state_d       = state_q;
    operr_d       = operr_q;
    xacc_d        = xacc_q;
    yacc_d        = yacc_q;
    sacc_d        = sacc_q;
    xacc_d.valid  = 1'b0;
    yacc_d.valid  = 1'b0;
    unique case (state_q)
      DAG_ST_IDLE:
      begin
        sacc_d.valid = 1'b0;
        if (dual_go)
        begin
          operr_d = dual_bad;
          // Both memories are reached in the same cycle, old pointers
          xacc_d  = '{op_in.x.en && !dual_bad, op_in.x.store,
                      op_in.x.data_sel, x_ptr_word};
          yacc_d  = '{op_in.y.en && !dual_bad, op_in.y.store,
                      op_in.y.data_sel, y_ptr_word};
        end
        else if (single_go)
        begin
          operr_d = single_bad;
          if (!single_bad)
          begin
            sacc_d  = '{1'b1, op_in.s_store, op_in.s_long, op_in.s_opnd,
                        (op_in.s_mode == DAG_UPD_DEC) ? s_new : s_ptr_cur};
            state_d = DAG_ST_WAIT;
          end
        end
      end
      DAG_ST_WAIT:
      begin
        if (idb_grant_in)
        begin
          sacc_d.valid = 1'b0;
          state_d      = DAG_ST_IDLE;
        end
      end
    endcase
    oprdy_d = (state_d == DAG_ST_IDLE);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = DAG_GPR_LO; i <= DAG_GPR_HI; i++)
        gpr_q[i] <= DAG_RST_WORD;
      ctrl_q    <= DAG_RST_MODE;
      modc_q    <= DAG_RST_WORD;
      state_q   <= DAG_ST_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= DAG_RST_WORD;
      oprdy_q   <= 1'b0;
      operr_q   <= 1'b0;
      xacc_q    <= '0;
      yacc_q    <= '0;
      sacc_q    <= '0;
    end
    else
    begin
      for (int i = DAG_GPR_LO; i <= DAG_GPR_HI; i++)
        gpr_q[i] <= gpr_d[i];
      ctrl_q    <= ctrl_d;
      modc_q    <= modc_d;
      state_q   <= state_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      oprdy_q   <= oprdy_d;
      operr_q   <= operr_d;
      xacc_q    <= xacc_d;
      yacc_q    <= yacc_d;
      sacc_q    <= sacc_d;
    end
  end

  assign pready_out   = pready_q;
  assign pslverr_out  = pslverr_q;
  assign prdata_out   = prdata_q;
  assign op_ready_out = oprdy_q;
  assign op_err_out   = operr_q;
  assign x_acc_out    = xacc_q;
  assign y_acc_out    = yacc_q;
  assign s_acc_out    = sacc_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  x_addr_old_a : assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    dual_go && op_in.x.en && !dual_bad
      |=> x_acc_out.valid && x_acc_out.addr == $past(x_ptr_word))
    else $error("X address not taken from old pointer");

  y_addr_old_a : assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    dual_go && op_in.y.en && !dual_bad
      |=> y_acc_out.valid && y_acc_out.addr == $past(y_ptr_word))
    else $error("Y address not taken from old pointer");

  upper_word_a : assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    dual_go |-> x_new[31:16] == x_ptr_cur[31:16] && y_new[31:16] == y_ptr_cur[31:16])
    else $error("Dual update touched upper word");

  inc_two_a : assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    dual_go && op_in.x.mode == DAG_UPD_INC && !x_mod_eff
      |-> x_new[15:0] == x_ptr_cur[15:0] + DAG_STEP_WORD[15:0])
    else $error("Dual increment is not two");

  mod_wrap_a : assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    dual_go && y_mod_eff && op_in.y.mode != DAG_UPD_NOP
      && y_ptr_cur[15:0] == modc_q[31:16]
      |-> y_new[15:0] == modc_q[15:0])
    else $error("Modulo end did not reload start");

  y_only_mod_a : assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    ctrl_q[DAG_BIT_XMOD] && ctrl_q[DAG_BIT_YMOD] |-> !x_mod_eff && y_mod_eff)
    else $error("Both modulo enables not resolved to Y");

  nop_hold_a : assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    dual_go && op_in.x.mode == DAG_UPD_NOP |-> x_new == x_ptr_cur)
    else $error("No-update mode changed pointer");

  predec_addr_a : assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    single_go && !single_bad && op_in.s_mode == DAG_UPD_DEC
      |=> s_acc_out.valid && s_acc_out.addr == $past(s_new))
    else $error("Pre-decrement address not the reduced pointer");

  postinc_addr_a : assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    single_go && !single_bad && op_in.s_mode == DAG_UPD_INC
      |=> s_acc_out.addr == $past(s_ptr_cur))
    else $error("Post-increment address not the old pointer");

  bus_hold_a : assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    s_acc_out.valid && !idb_grant_in
      |=> s_acc_out.valid && $stable(s_acc_out.addr) && !op_ready_out)
    else $error("Single access dropped before grant");

  bad_opnd_a : assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    single_go && single_bad |=> op_err_out && !s_acc_out.valid)
    else $error("Reserved operand code was issued");

endmodule

/* File: tb/dag_bus_model.sv */
/*
  Partner model of the internal bus seen by single transfers.
  Assumes the request is the registered single access valid of the block.
*/
`timescale 1ns/1ps

module dag_bus_model (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       req_in,
  input  wire logic [3:0] wait_in,
  output logic            grant_out
);
  logic [3:0] cnt_q;

  // Contention: grant only after the chosen number of busy cycles
  assign grant_out = req_in && (cnt_q == wait_in);

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_q <= 4'h0;
    else if (req_in && !grant_out)
      cnt_q <= cnt_q + 4'h1;
    else
      cnt_q <= 4'h0;
  end
endmodule

/* File: tb/tb.sv */
/*
  Testbench of the data address generator: APB access, dual and single
  transfers. Assumes dag_core and dag_bus_model.
*/
`timescale 1ns/1ps

module tb;
  import dag_pkg::*;
  logic            sys_clk_in  = 1'b0;
  logic            rst_in      = 1'b1;
  logic            psel_in     = 1'b0;
  logic            penable_in  = 1'b0;
  logic            pwrite_in   = 1'b0;
  logic [7:0]      paddr_in    = 8'h00;
  logic [31:0]     pwdata_in   = 32'h0;
  logic            op_valid_in = 1'b0;
  dag_op_t         op_in       = '0;
  logic [3:0]      wt          = 4'h0;
  logic            pready_out, pslverr_out, op_ready_out, op_err_out, grant;
  logic [31:0]     prdata_out;
  dag_xy_acc_t     x_acc_out, y_acc_out, xa, ya;
  dag_single_acc_t s_acc_out, sa;
  int              err_total   = 0;
  int              cmp_count   = 0;
  int              bw          = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  dag_core dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .prdata_out(prdata_out),
    .pslverr_out(pslverr_out), .op_valid_in(op_valid_in), .op_in(op_in),
    .op_ready_out(op_ready_out), .op_err_out(op_err_out), .x_acc_out(x_acc_out),
    .y_acc_out(y_acc_out), .s_acc_out(s_acc_out), .idb_grant_in(grant));
  dag_bus_model bus (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .req_in(s_acc_out.valid), .wait_in(wt), .grant_out(grant));

  // ==========================================
  // Shared tasks
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic stop_test();
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] ra(input int n);
    return DAG_OFS_GPR_BASE + 8'(4 * (n - 2));
  endfunction

  function automatic dag_op_t dual(input logic xe, xs, input dag_upd_t xm,
                                   input logic ye, ys, input dag_upd_t ym);
    return {1'b0, xe, xs, xm, 2'b00, ye, ys, ym, 2'b11, 10'h000};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x,
                     input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(n, 64'(x), 64'(q));
    chk({n, "_err"}, 64'(xe), 64'(e));
  endtask

  task automatic run(input dag_op_t o, input logic [3:0] w);
    wt <= w;
    op_in <= o;
    op_valid_in <= 1'b1;
    do @(posedge sys_clk_in); while (op_ready_out !== 1'b1);
    op_valid_in <= 1'b0;
    @(posedge sys_clk_in);
    xa = x_acc_out;
    ya = y_acc_out;
    sa = s_acc_out;
    // Count the edges at which the single access still waits for grant
    bw = 0;
    while (s_acc_out.valid === 1'b1 && bw < 20)
    begin
      chk("op_ready_busy", 64'h0, 64'(op_ready_out));
      @(posedge sys_clk_in);
      bw++;
    end
  endtask

  task automatic sgl(input logic [1:0] s, input dag_upd_t m, input logic lg, st,
                     input logic [3:0] od, w, input logic [31:0] a0, ep);
    logic [31:0] ea;
    ea = (m == DAG_UPD_DEC) ? ep : a0;
    wr(ra(2 + int'(s)), a0);
    run({1'b1, 12'h000, s, m, lg, st, od}, w);
    chk("s_acc", 64'({1'b1, st, lg, od, ea}), 64'(sa));
    // The bus model grants after w busy edges, so the request stands w+1 edges
    chk("s_busy", 64'(w) + 64'h1, 64'(bw));
    chk("op_ready", 64'h1, 64'(op_ready_out));
    chk("op_err", 64'h0, 64'(op_err_out));
    rdc("s_ptr", ra(2 + int'(s)), ep, 1'b0);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rdc("status", DAG_OFS_STATUS_REG, DAG_RST_WORD, 1'b0);
    rdc("modc", DAG_OFS_MOD_CTRL, DAG_RST_WORD, 1'b0);
    for (int n = 2; n < 10; n++)
      wr(ra(n), 32'hA5000000 | 32'(n));
    for (int n = 2; n < 10; n++)
      rdc("gpr", ra(n), 32'hA5000000 | 32'(n), 1'b0);
    rdc("unmapped", 8'h10, 32'h0, 1'b1);
    apb(1'b1, DAG_OFS_STATE, 32'hFFFFFFFF, q, e);
    chk("ro_write", 64'h1, 64'(e));
  endtask

  task automatic t_mod();
    wr(DAG_OFS_MOD_CTRL, 32'hC00CC008);
    rdc("modc", DAG_OFS_MOD_CTRL, 32'hC00CC008, 1'b0);
    wr(DAG_OFS_STATUS_REG, 32'h00000001);
    // Buffer kept inside one 64K page of the pointer
    wr(ra(4), 32'h0001C008);
    wr(ra(6), 32'h12340010);
    // Even index of minus two steps the Y pointer downward
    wr(ra(9), 32'hFFFFFFFE);
    for (int i = 0; i < 3; i++)
    begin
      run(dual(1'b1, 1'b0, DAG_UPD_INC, 1'b1, 1'b0, DAG_UPD_IDX), 4'h0);
      chk("x_acc", 64'({3'b100, 15'(15'h6004 + i)}), 64'(xa));
      chk("y_acc", 64'({3'b111, 15'(15'h0008 - i)}), 64'(ya));
    end
    rdc("r4", ra(4), 32'h0001C008, 1'b0);
    rdc("r6", ra(6), 32'h1234000A, 1'b0);
  endtask

  task automatic t_edge();
    wr(DAG_OFS_STATUS_REG, 32'h00000003);
    wr(ra(5), 32'h0000C00C);
    wr(ra(7), 32'h0000C00C);
    run(dual(1'b1, 1'b1, DAG_UPD_INC, 1'b1, 1'b1, DAG_UPD_INC), 4'h0);
    rdc("r5", ra(5), 32'h0000C00E, 1'b0);
    rdc("r7", ra(7), 32'h0000C008, 1'b0);
    wr(DAG_OFS_STATUS_REG, 32'h00000001);
    wr(ra(5), 32'h0000C00C);
    run(dual(1'b1, 1'b1, DAG_UPD_NOP, 1'b0, 1'b0, DAG_UPD_INC), 4'h0);
    chk("y_idle", 64'h0, 64'(ya.valid));
    rdc("r5n", ra(5), 32'h0000C00C, 1'b0);
    wr(ra(4), 32'h0000C00A);
    wr(ra(8), 32'h00000004);
    run(dual(1'b1, 1'b0, DAG_UPD_IDX, 1'b0, 1'b0, DAG_UPD_NOP), 4'h0);
    rdc("r4i", ra(4), 32'h0000C00E, 1'b0);
    rdc("r7k", ra(7), 32'h0000C008, 1'b0);
  endtask

  task automatic t_single();
    wr(ra(8), 32'h00000010);
    sgl(2'h0, DAG_UPD_INC, 1'b0, 1'b0, 4'h5, 4'h0, 32'h00100000, 32'h00100002);
    sgl(2'h1, DAG_UPD_INC, 1'b1, 1'b1, 4'hF, 4'h3, 32'h00002000, 32'h00002004);
    sgl(2'h2, DAG_UPD_DEC, 1'b0, 1'b0, 4'h7, 4'h1, 32'h00003000, 32'h00002FFE);
    sgl(2'h3, DAG_UPD_DEC, 1'b1, 1'b1, 4'h8, 4'h2, 32'h00004000, 32'h00003FFC);
    sgl(2'h0, DAG_UPD_IDX, 1'b1, 1'b0, 4'hD, 4'h0, 32'h0001FFFE, 32'h0002000E);
    sgl(2'h1, DAG_UPD_NOP, 1'b0, 1'b1, 4'hC, 4'h1, 32'h00005000, 32'h00005000);
  endtask

  task automatic t_bad();
    wr(ra(4), 32'h00001000);
    run(dual(1'b1, 1'b0, DAG_UPD_DEC, 1'b0, 1'b0, DAG_UPD_NOP), 4'h0);
    chk("dec_err", 64'h1, 64'(op_err_out));
    chk("dec_acc", 64'h0, 64'(xa.valid));
    rdc("state", DAG_OFS_STATE, 32'h00000002, 1'b0);
    run({1'b1, 12'h000, 2'h2, DAG_UPD_INC, 1'b0, 1'b0, 4'h6}, 4'h0);
    chk("opnd_err", 64'h1, 64'(op_err_out));
    chk("opnd_acc", 64'h0, 64'(sa.valid));
    rdc("r4d", ra(4), 32'h00001000, 1'b0);
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    t_regs();
    t_mod();
    t_edge();
    t_single();
    t_bad();
    stop_test();
  end

  initial
  begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule
